// ==== verilog/dgc_top.sv ====
// Notes on behaviour
// - Both mode selects low: gain follows the parallel gain word.
// - High/low mode selects: pulse mode, gain moves only via up/down.
// - Low/high mode selects: gain set only over serial interface.
// - Latch asserted in parallel mode: gain follows word one mclk later.
// - Latch released: last gain kept, word changes ignored.
// - Gain word binary weighted, lsb 0.5dB up to msb 16dB.
// - Active-low enable per channel; low enables the channel.
// - Up pulse raises gain one step, down pulse lowers one step.
// - Step size: 11 0.5dB, 10 1dB, 01 2dB, 00 6dB.
// - Each channel keeps its own step-size selection.
// - In pulse mode gain bits 2 and 1 are step-size selects.
`timescale 1ns/10ps
`default_nettype none
module dgc_top
  import dgc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic              mode_select_hi,
  input  wire logic              mode_select_lo,
  input  wire logic [GAIN_W-1:0] gain_switch_bank_a,
  input  wire logic [GAIN_W-1:0] gain_switch_bank_b,
  input  wire logic              gain_latch_ch_a,
  input  wire logic              gain_latch_ch_b,
  input  wire logic              chan_a_enable_n,
  input  wire logic              chan_b_enable_n,
  input  wire logic              step_up_ch_a,
  input  wire logic              step_up_ch_b,
  input  wire logic              step_down_ch_a,
  input  wire logic              step_down_ch_b,
  input  wire logic              spi_sclk,
  input  wire logic              spi_sdi,
  input  wire logic              spi_cs_n,
  output logic      [GAIN_W-1:0] gain_ch_a,
  output logic      [GAIN_W-1:0] gain_ch_b,
  output logic                   chan_a_active,
  output logic                   chan_b_active,
  output logic                   mode_fault,
  output logic      [15:0]       spi_word,
  output logic                   spi_word_valid
);
  logic [1:0]  mode;
  logic        sclk_q, sclk_d, cs_q, cs_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d, word_q, word_d;
  logic        vld_q, vld_d;
  logic        act_a_q, act_a_d, act_b_q, act_b_d, flt_q, flt_d;
  logic        load_a, load_b;
  logic [GAIN_W-1:0] bank_w [2];
  logic [GAIN_W-1:0] gain_w [2];
  logic [1:0]  latch_w, up_w, dn_w, load_w;

  assign mode = {mode_select_hi, mode_select_lo};

  // Serial frame: mode 3, data taken on rising sclk, 16 bits
  // Sclk is oversampled, so it must stay below mclk/2.
  always_comb begin
    sclk_d = spi_sclk;
    cs_d   = spi_cs_n;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    word_d = word_q;
    vld_d  = 1'b0;
    if (spi_cs_n) begin
      cnt_d = SPI_CNT_RST;
    end else if (spi_sclk && !sclk_q) begin
      sh_d  = {sh_q[14:0], spi_sdi};
      cnt_d = (cnt_q == 5'(SPI_BITS)) ? cnt_q : cnt_q + 5'h01;
    end
    // Word commits at chip-select release, frames under 16 bits dropped
    if (spi_cs_n && !cs_q && cnt_q == 5'(SPI_BITS)) begin
      word_d = sh_q;
      vld_d  = (mode == DGC_MODE_SERIAL);
    end
  end

  // Bits 5 to 0 carry the gain; bit 8 picks the channel
  assign load_a = vld_q && !word_q[8];
  assign load_b = vld_q && word_q[8];

  always_comb begin
    act_a_d = !chan_a_enable_n;
    act_b_d = !chan_b_enable_n;
    // Channel B bit 5 low outside parallel mode leaves the part undefined
    flt_d = (mode == DGC_MODE_BAD) ||
            (mode != DGC_MODE_PARALLEL && !gain_switch_bank_b[5]);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclk_q  <= 1'b1;
      cs_q    <= 1'b1;
      cnt_q   <= SPI_CNT_RST;
      sh_q    <= SPI_WORD_RST;
      word_q  <= SPI_WORD_RST;
      vld_q   <= 1'b0;
    end else begin
      sclk_q  <= sclk_d;
      cs_q    <= cs_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      word_q  <= word_d;
      vld_q   <= vld_d;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      act_a_q <= 1'b0;
      act_b_q <= 1'b0;
      flt_q   <= 1'b0;
    end else begin
      act_a_q <= act_a_d;
      act_b_q <= act_b_d;
      flt_q   <= flt_d;
    end
  end

  assign bank_w[0] = gain_switch_bank_a;
  assign bank_w[1] = gain_switch_bank_b;
  assign latch_w   = {gain_latch_ch_b, gain_latch_ch_a};
  assign up_w      = {step_up_ch_b, step_up_ch_a};
  assign dn_w      = {step_down_ch_b, step_down_ch_a};
  assign load_w    = {load_b, load_a};

  // One instance per channel keeps step size per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    dgc_channel u_ch (
      .mclk       (mclk),
      .nrst       (nrst),
      .mode       (mode),
      .gain_word  (bank_w[ch]),
      .gain_latch (latch_w[ch]),
      .step_up    (up_w[ch]),
      .step_down  (dn_w[ch]),
      .spi_load   (load_w[ch]),
      .spi_gain   (word_q[5:0]),
      .gain       (gain_w[ch])
    );
  end

  assign gain_ch_a      = gain_w[0];
  assign gain_ch_b      = gain_w[1];

  assign chan_a_active  = act_a_q;
  assign chan_b_active  = act_b_q;
  assign mode_fault     = flt_q;
  assign spi_word       = word_q;
  assign spi_word_valid = vld_q;

  chk_enable_low: assert property (
    @(posedge mclk) disable iff (!nrst)
    !chan_a_enable_n |=> chan_a_active)
    else $error("channel a not enabled by low enable");
  chk_enable_b: assert property (
    @(posedge mclk) disable iff (!nrst)
    !chan_b_enable_n |=> chan_b_active)
    else $error("channel b not enabled by low enable");
  chk_disable_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    chan_a_enable_n |=> !chan_a_active)
    else $error("channel a active with high enable");
  chk_disable_b: assert property (
    @(posedge mclk) disable iff (!nrst)
    chan_b_enable_n |=> !chan_b_active)
    else $error("channel b active with high enable");

  chk_serial_only: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_SERIAL && !vld_q) |=> $stable(gain_ch_a))
    else $error("gain moved in serial mode without a word");
  chk_serial_only_b: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_SERIAL && !vld_q) |=> $stable(gain_ch_b))
    else $error("channel b gain moved in serial mode without a word");
  chk_load_a: assert property (
    @(posedge mclk) disable iff (!nrst)
    (vld_q && !word_q[8] && mode == DGC_MODE_SERIAL)
    |=> gain_ch_a == $past(word_q[5:0]))
    else $error("channel a missed serial gain");
  chk_load_b: assert property (
    @(posedge mclk) disable iff (!nrst)
    (vld_q && word_q[8] && mode == DGC_MODE_SERIAL)
    |=> gain_ch_b == $past(word_q[5:0]))
    else $error("channel b missed serial gain");
  chk_valid_serial: assert property (
    @(posedge mclk) disable iff (!nrst)
    vld_q |-> $past(mode) == DGC_MODE_SERIAL)
    else $error("word valid outside serial mode");

  // Word may only move at the end of a frame
  chk_word_stable: assert property (
    @(posedge mclk) disable iff (!nrst)
    !(spi_cs_n && !cs_q) |=> $stable(spi_word))
    else $error("serial word moved without frame end");
  chk_short_frame: assert property (
    @(posedge mclk) disable iff (!nrst)
    (spi_cs_n && !cs_q && cnt_q != 5'(SPI_BITS)) |=> !vld_q)
    else $error("short frame taken as a word");
  chk_spi_len: assert property (
    @(posedge mclk) disable iff (!nrst)
    vld_q |-> $past(cnt_q, 2) == 5'h10)
    else $error("word taken with wrong bit count");

  chk_b5_fault: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PULSE && !gain_switch_bank_b[5]) |=> mode_fault)
    else $error("missing fault on low channel b bit 5");
  chk_serial_fault: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_SERIAL && !gain_switch_bank_b[5]) |=> mode_fault)
    else $error("missing fault on low bit 5 in serial mode");
  chk_parallel_fault: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PARALLEL) |=> !mode_fault)
    else $error("fault raised in parallel mode");
  chk_bad_mode: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_BAD)
    |=> mode_fault && $stable(gain_ch_a) && $stable(gain_ch_b))
    else $error("invalid mode did not hold gain and flag fault");
  cov_serial: cover property (@(posedge mclk) spi_word_valid);
  cov_par_load: cover property (@(posedge mclk)
    mode == DGC_MODE_PARALLEL && gain_latch_ch_b ##1 !gain_latch_ch_b);
  cov_fault: cover property (@(posedge mclk) mode_fault);
endmodule : dgc_top
`default_nettype wire

// ==== verilog/dgc_pkg.sv ====
package dgc_pkg;
  localparam int unsigned GAIN_W      = 6;
  localparam logic [5:0]  GAIN_MAX    = 6'h3f;
  localparam logic [5:0]  GAIN_MIN    = 6'h00;
  localparam logic [5:0]  GAIN_RST    = 6'h00;
  localparam logic [5:0]  STEP_0P5DB  = 6'h01;
  localparam logic [5:0]  STEP_1DB    = 6'h02;
  localparam logic [5:0]  STEP_2DB    = 6'h04;
  localparam logic [5:0]  STEP_6DB    = 6'h0c;
  localparam int unsigned SIZE_MSB_POS = 2;
  localparam int unsigned SIZE_LSB_POS = 1;
  localparam int unsigned SPI_BITS    = 16;
  localparam logic [4:0]  SPI_CNT_RST = 5'h00;
  localparam logic [15:0] SPI_WORD_RST = 16'h0000;

  typedef enum logic [1:0] {
    DGC_MODE_PARALLEL = 2'b00,
    DGC_MODE_PULSE    = 2'b10,
    DGC_MODE_SERIAL   = 2'b01,
    DGC_MODE_BAD      = 2'b11
  } dgc_mode_t;
endpackage : dgc_pkg

// ==== verilog/dgc_channel.sv ====
`timescale 1ns/10ps
`default_nettype none
module dgc_channel
  import dgc_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              nrst,
  input  wire logic [1:0]        mode,
  input  wire logic [GAIN_W-1:0] gain_word,
  input  wire logic              gain_latch,
  input  wire logic              step_up,
  input  wire logic              step_down,
  input  wire logic              spi_load,
  input  wire logic [GAIN_W-1:0] spi_gain,
  output logic      [GAIN_W-1:0] gain
);
  logic [GAIN_W-1:0] gain_q, gain_d;
  logic              up_q, up_d, dn_q, dn_d;
  logic [GAIN_W-1:0] step;
  logic              up_evt, dn_evt;
  logic [GAIN_W:0]   sum;

  always_comb begin
    // Bits 2 and 1 pick the increment in pulse mode
    case ({gain_word[SIZE_MSB_POS], gain_word[SIZE_LSB_POS]})
      2'b11:   step = STEP_0P5DB;
      2'b10:   step = STEP_1DB;
      2'b01:   step = STEP_2DB;
      default: step = STEP_6DB;
    endcase
  end

  // Rising edge only, so one action per press
  assign up_evt = step_up & ~up_q;
  assign dn_evt = step_down & ~dn_q;

  always_comb begin
    up_d   = step_up;
    dn_d   = step_down;
    gain_d = gain_q;
    sum    = {1'b0, gain_q};
    case (dgc_mode_t'(mode))
      DGC_MODE_PARALLEL: begin
        if (gain_latch) begin
          gain_d = gain_word;
        end
      end
      DGC_MODE_PULSE: begin
        // Both pressed together cancel out
        if (up_evt && !dn_evt) begin
          sum    = {1'b0, gain_q} + {1'b0, step};
          gain_d = sum[GAIN_W] ? GAIN_MAX : sum[GAIN_W-1:0];
        end else if (dn_evt && !up_evt) begin
          gain_d = (gain_q < step) ? GAIN_MIN : gain_q - step;
        end
      end
      DGC_MODE_SERIAL: begin
        if (spi_load) begin
          gain_d = spi_gain;
        end
      end
      default: gain_d = gain_q;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gain_q <= GAIN_RST;
      up_q   <= 1'b0;
      dn_q   <= 1'b0;
    end else begin
      gain_q <= gain_d;
      up_q   <= up_d;
      dn_q   <= dn_d;
    end
  end

  assign gain = gain_q;

  chk_hold_latch: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PARALLEL && !gain_latch) |=> $stable(gain_q))
    else $error("gain moved while latch closed");
  chk_transparent: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PARALLEL && gain_latch) |=> gain_q == $past(gain_word))
    else $error("transparent latch did not follow word");
  // A fresh down press while up is held still steps
  chk_one_step: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PULSE && step_up && up_q && !dn_evt)
    |=> $stable(gain_q))
    else $error("held button stepped twice");
  chk_step_up: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PULSE && up_evt && !dn_evt &&
     {1'b0, gain_q} + {1'b0, step} <= 7'h3f)
    |=> gain_q == $past(gain_q) + $past(step))
    else $error("up step wrong");
  chk_floor: assert property (
    @(posedge mclk) disable iff (!nrst)
    (mode == DGC_MODE_PULSE && dn_evt && !up_evt && gain_q < step)
    |=> gain_q == GAIN_MIN)
    else $error("gain fell past floor");
  chk_size_6db: assert property (
    @(posedge mclk) disable iff (!nrst)
    (gain_word[2:1] == 2'b00) |-> step == STEP_6DB)
    else $error("step size decode wrong");
  cov_up: cover property (@(posedge mclk) mode == DGC_MODE_PULSE && up_evt);
  cov_ceiling: cover property (@(posedge mclk) sum[GAIN_W]);
endmodule : dgc_channel
`default_nettype wire

// ==== verif/dgc_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module dgc_ctrl_model (
  input  wire logic mclk,
  output logic      sclk,
  output logic      sdi,
  output logic      cs_n
);
  initial begin
    sclk = 1'h1;
    sdi  = 1'h0;
    cs_n = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // Idle high clock, msb first, two mclk per half period
  task automatic send(input logic [15:0] w, input int nbits);
    cs_n = 1'h0;
    tick(2);
    for (int i = 15; i > 15 - nbits; i--) begin
      sclk = 1'h0;
      sdi  = w[i];
      tick(2);
      sclk = 1'h1;
      tick(2);
    end
    cs_n = 1'h1;
    // Deselected line shows stale-inverse, never last bit
    sdi = ~sdi;
    tick(2);
  endtask : send
endmodule : dgc_ctrl_model
`default_nettype wire

// ==== verif/dgc_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  bad_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module dgc_top_tb;
  import dgc_pkg::*;
  logic        mclk, nrst, msh, msl, lat_a, lat_b, en_a_n, en_b_n;
  logic        up_a, up_b, dn_a, dn_b, sclk, sdi, cs_n;
  logic        act_a, act_b, fault, vld;
  logic [5:0]  bank_a, bank_b, g_a, g_b;
  logic [15:0] word, got_word;
  int          bad_count, check_count, seed;
  int          cyc = 0;
  int          vld_cnt = 0;

  dgc_top DUT (.mclk(mclk), .nrst(nrst), .mode_select_hi(msh),
    .mode_select_lo(msl), .gain_switch_bank_a(bank_a),
    .gain_switch_bank_b(bank_b), .gain_latch_ch_a(lat_a),
    .gain_latch_ch_b(lat_b), .chan_a_enable_n(en_a_n),
    .chan_b_enable_n(en_b_n), .step_up_ch_a(up_a), .step_up_ch_b(up_b),
    .step_down_ch_a(dn_a), .step_down_ch_b(dn_b), .spi_sclk(sclk),
    .spi_sdi(sdi), .spi_cs_n(cs_n), .gain_ch_a(g_a), .gain_ch_b(g_b),
    .chan_a_active(act_a), .chan_b_active(act_b), .mode_fault(fault),
    .spi_word(word), .spi_word_valid(vld));
  dgc_ctrl_model PM (.mclk(mclk), .sclk(sclk), .sdi(sdi), .cs_n(cs_n));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Valid is a one-cycle pulse, so catch it on every edge
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (vld === 1'h1) begin
      vld_cnt  <= vld_cnt + 1;
      got_word <= word;
    end
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  function logic [5:0] step_of(input logic [1:0] s);
    case (s)
      2'h3: return 6'h01;
      2'h2: return 6'h02;
      2'h1: return 6'h04;
      default: return 6'h0c;
    endcase
  endfunction : step_of

  function logic [5:0] sat(input int v);
    return v > 63 ? 6'h3f : (v < 0 ? 6'h00 : 6'(v));
  endfunction : sat

  // Word settles a cycle before the latch pulse
  task pload(input logic [5:0] a, input logic [5:0] b);
    {msh, msl} = 2'h0;
    bank_a = a;
    bank_b = b;
    tick(1);
    {lat_a, lat_b} = 2'h3;
    tick(2);
    {lat_a, lat_b} = 2'h0;
    tick(1);
  endtask : pload

  initial begin
    logic [5:0]  a, b, ea, eb;
    logic [1:0]  s, en;
    logic [15:0] w;
    int          vc;
    seed = 82614;
    {nrst, msh, msl, lat_a, lat_b, up_a, up_b, dn_a, dn_b} = 9'h0;
    {en_a_n, en_b_n} = 2'h3;
    bank_a = 6'h00;
    bank_b = 6'h00;
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'h1;
    tick(1);
    for (int i = 0; i < 8; i++) begin
      a = 6'($random(seed));
      b = 6'($random(seed));
      en = 2'($random(seed));
      {en_a_n, en_b_n} = en;
      bank_a = a;
      bank_b = b;
      {lat_a, lat_b} = 2'h3;
      tick(2);
      `CHK("gain_a", a, g_a)
      `CHK("gain_b", b, g_b)
      `CHK("act_a", ~en[1], act_a)
      `CHK("act_b", ~en[0], act_b)
      lat_b = 1'h0;
      bank_a = ~a;
      bank_b = ~b;
      tick(2);
      `CHK("gain_a", ~a, g_a)
      `CHK("gain_b", b, g_b)
    end
    lat_a = 1'h0;
    for (int k = 0; k < 4; k++) begin
      s = 2'(k);
      a = (k == 0) ? 6'h3e : 6'($random(seed));
      b = (k == 0) ? 6'h00 : 6'($random(seed));
      pload(a, b);
      bank_a = {3'h4, s, 1'h1};
      bank_b = {3'h4, ~s, 1'h1};
      {en_a_n, en_b_n, msh} = 3'h1;
      tick(2);
      `CHK("fault", 1'h0, fault)
      {up_a, dn_b} = 2'h3;
      tick(4);
      ea = sat(int'(a) + int'(step_of(s)));
      eb = sat(int'(b) - int'(step_of(~s)));
      `CHK("gain_a", ea, g_a)
      `CHK("gain_b", eb, g_b)
      {up_a, dn_b, dn_a, up_b} = 4'h3;
      tick(3);
      {dn_a, up_b} = 2'h0;
      ea = sat(int'(ea) - int'(step_of(s)));
      eb = sat(int'(eb) + int'(step_of(~s)));
      `CHK("gain_a", ea, g_a)
      `CHK("gain_b", eb, g_b)
    end
    bank_b[5] = 1'h0;
    tick(2);
    `CHK("fault", 1'h1, fault)
    bank_b[5] = 1'h1;
    msl = 1'h1;
    tick(2);
    `CHK("fault", 1'h1, fault)
    `CHK("gain_a", ea, g_a)
    `CHK("gain_b", eb, g_b)
    msh = 1'h0;
    {lat_a, lat_b} = 2'h3;
    bank_a = 6'($random(seed));
    bank_b = 6'($random(seed)) | 6'h20;
    for (int k = 0; k < 6; k++) begin
      w = 16'($random(seed));
      w[8] = k[0];
      vc = vld_cnt;
      PM.send(w, (k == 5) ? 15 : 16);
      tick(3);
      if (k < 5) begin
        if (w[8]) eb = w[5:0];
        else ea = w[5:0];
        `CHK("word", w, got_word)
      end
      `CHK("vld_cnt", vc + (k < 5 ? 1 : 0), vld_cnt)
      `CHK("gain_a", ea, g_a)
      `CHK("gain_b", eb, g_b)
    end
    bank_b[5] = 1'h0;
    tick(2);
    `CHK("fault", 1'h1, fault)
    `CHK("gain_b", eb, g_b)
    print_verdict();
  end
endmodule : dgc_top_tb
`default_nettype wire
